//--- design/pirq_pkg.sv
// package: register map, field positions and reset values of the peripheral irq block
package pirq_pkg;
  // ==========================================================================
  // register byte offsets on the apb
  localparam logic [7:0] flags_a_off = 8'h00;
  localparam logic [7:0] flags_b_off = 8'h04;
  localparam logic [7:0] enables_a_off = 8'h08;
  localparam logic [7:0] enables_b_off = 8'h0c;
  localparam logic [7:0] prio_a_off = 8'h10;
  localparam logic [7:0] prio_b_off = 8'h14;
  localparam logic [7:0] core_ctrl_off = 8'h18;
  localparam logic [7:0] request_off = 8'h1c;
  // ==========================================================================
  // implemented bit masks
  localparam logic [7:0] mask_a = 8'h7f;
  localparam logic [7:0] mask_b = 8'hfe;
  // software-writable flag bits (rx full and tx empty are read-only)
  localparam logic [7:0] flag_wr_mask_a = 8'h4f;
  // ==========================================================================
  // bit positions, register a
  localparam int converter_done_bit = 6;
  localparam int rx_full_bit = 5;
  localparam int tx_empty_bit = 4;
  localparam int sync_port_done_bit = 3;
  localparam int capcmp_event_bit = 2;
  localparam int timer_b_match_bit = 1;
  localparam int timer_a_overflow_bit = 0;
  // bit positions, register b
  localparam int osc_fail_bit = 7;
  localparam int comparator_one_bit = 6;
  localparam int comparator_two_bit = 5;
  localparam int nv_write_done_bit = 4;
  localparam int bus_collision_bit = 3;
  localparam int usb_request_bit = 2;
  localparam int timer_c_overflow_bit = 1;
  // core control register bits
  localparam int priority_levels_enable_bit = 0;
  localparam int high_level_global_enable_bit = 1;
  localparam int low_level_global_enable_bit = 2;
  // ==========================================================================
  // reset values
  localparam logic [7:0] flags_rst = 8'h00;
  localparam logic [7:0] enables_rst = 8'h00;
  localparam logic [7:0] prio_a_rst = 8'h7f;
  localparam logic [7:0] prio_b_rst = 8'hfe;
  localparam logic [2:0] core_ctrl_rst = 3'h0;
  // capture/compare unit modes
  typedef enum logic [1:0] {
    pirq_ccp_capture = 2'b00,
    pirq_ccp_compare = 2'b01,
    pirq_ccp_pwm = 2'b10,
    pirq_ccp_off = 2'b11
  } pirq_ccp_mode_type;
endpackage : pirq_pkg

//--- design/pirq_flag_bank.sv
// one bank of eight event flags, sticky or level-following, with software write
`timescale 1ns/1ps
module pirq_flag_bank #(
  parameter logic [7:0] impl_mask = 8'hff, // implemented bits
  parameter logic [7:0] wr_mask = 8'hff // software writable bits
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, low
  input wire logic clk_en, // freeze when low
  input wire logic [7:0] event_set, // one-cycle event pulses
  input wire logic [7:0] level_val, // level-driven flag values
  input wire logic [7:0] level_sel, // bits that follow a level
  input wire logic wr_en, // software write strobe
  input wire logic [7:0] wr_data, // software write data
  output logic [7:0] flags // current flags
);
  typedef struct packed {
    logic [7:0] flag_reg;
  } pirq_bank_state_type;
  pirq_bank_state_type st_reg, st_next;

  // ==========================================================================
  // per bit next value
  always_comb begin
    st_next = st_reg;
    if (clk_en) begin
      for (int i = 0; i < 8; i++) begin
        if (!impl_mask[i]) begin
          st_next.flag_reg[i] = 1'b0;
        end else if (level_sel[i]) begin
          st_next.flag_reg[i] = level_val[i];
        end else if (event_set[i]) begin
          st_next.flag_reg[i] = 1'b1;
        end else if (wr_en && wr_mask[i]) begin
          st_next.flag_reg[i] = wr_data[i];
        end
      end
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign flags = st_reg.flag_reg;

  a_event_wins: assert property (@(posedge pclk)
    disable iff (!presetn)
    (clk_en && |(event_set & impl_mask & ~level_sel)) |=>
    ((flags & $past(event_set & impl_mask & ~level_sel))
     == $past(event_set & impl_mask & ~level_sel)))
    else $error("event flag not set");
  a_unimpl_zero: assert property (@(posedge pclk)
    disable iff (!presetn)
    (flags & ~impl_mask) == 8'h00)
    else $error("unimplemented flag bit set");
endmodule : pirq_flag_bank

//--- design/pirq_router.sv
// combinational routing of enabled flags to high and low requests
`timescale 1ns/1ps
module pirq_router (
  input wire logic [15:0] flags, // both flag banks
  input wire logic [15:0] enables, // both enable banks
  input wire logic [15:0] prios, // both priority banks
  input wire logic prio_en, // priority levels enable
  input wire logic gen_high, // global or high-level enable
  input wire logic gen_low, // group or low-level enable
  output logic req_high, // high vector request
  output logic req_low // low vector request
);
  logic [15:0] active;
  logic any_hi;
  logic any_lo;

  // pending and enabled sources, then split by priority
  always_comb begin
    active = flags & enables;
    any_hi = |(active & prios);
    any_lo = |(active & ~prios);
    if (prio_en) begin
      req_high = any_hi && gen_high;
      req_low = any_lo && gen_low;
    end else begin
      req_high = (|active) && gen_high && gen_low;
      req_low = 1'b0;
    end
  end
endmodule : pirq_router

//--- design/pirq_top.sv
// peripheral interrupt flag, enable and priority block with apb registers
// Overview of operation
// - flags set on event regardless of enables
// - without priorities, group enable also required
// - priority bits used only when levels enabled
// - priority one means high, resets high
// - flag register a layout, bit 7 zero
// - rx full flag read-only, follows buffer
// - tx empty flag read-only, follows buffer
// - capture/compare flag set per unit mode
// - timer match and overflow flags software-cleared
// - flag register b layout, bit 0 zero
// - usb flag sticky until software clears
// - enable register a mirrors flags, resets zero
// - enable register b mirrors flags, resets zero
// - priority registers mirror flags, reset one
// - request needs flag, enable, global enable
// - levels use high and low global enables
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/1ps
module pirq_top (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic clk_en, // freeze all state when low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb byte strobes
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic converter_done, // conversion complete pulse
  input wire logic rx_buffer_full, // serial rx buffer holds data
  input wire logic tx_buffer_empty, // serial tx buffer empty
  input wire logic sync_port_done, // sync port transfer done pulse
  input wire logic [1:0] capcmp_mode, // capture/compare unit mode
  input wire logic timer_a_capture, // timer a capture pulse
  input wire logic timer_a_compare, // timer a compare match pulse
  input wire logic timer_b_match, // timer b equals period pulse
  input wire logic timer_a_overflow, // timer a overflow pulse
  input wire logic osc_fail, // switched to internal oscillator
  input wire logic comparator_one, // comparator one changed
  input wire logic comparator_two, // comparator two changed
  input wire logic nv_write_done, // nonvolatile write complete
  input wire logic bus_collision, // bus collision pulse
  input wire logic usb_request, // usb engine requests service
  input wire logic timer_c_overflow, // timer c overflow pulse
  output logic req_high, // request to high vector
  output logic req_low // request to low vector
);
  typedef struct packed {
    logic [7:0] enables_a_reg;
    logic [7:0] enables_b_reg;
    logic [7:0] prio_a_reg;
    logic [7:0] prio_b_reg;
    logic [2:0] core_ctrl_reg;
    logic [31:0] rdata_reg;
    logic slverr_reg;
    logic req_high_reg;
    logic req_low_reg;
  } pirq_state_type;
  pirq_state_type st_reg, st_next;

  logic [7:0] flags_a;
  logic [7:0] flags_b;
  logic [7:0] set_a;
  logic [7:0] set_b;
  logic [7:0] lvl_a;
  logic wr_flags_a;
  logic wr_flags_b;
  logic wr_access;
  logic rd_access;
  logic hit;
  logic capcmp_set;
  logic route_high;
  logic route_low;
  pirq_pkg::pirq_ccp_mode_type ccp_mode;

  // ==========================================================================
  // apb decode, zero wait states
  assign pready = 1'b1;
  assign pslverr = st_reg.slverr_reg;
  assign prdata = st_reg.rdata_reg;
  assign wr_access = psel && penable && pwrite && pstrb[0] && clk_en;
  assign rd_access = psel && penable && !pwrite && clk_en;
  assign wr_flags_a = wr_access && (paddr == pirq_pkg::flags_a_off);
  assign wr_flags_b = wr_access && (paddr == pirq_pkg::flags_b_off);
  assign hit = (paddr == pirq_pkg::flags_a_off) ||
               (paddr == pirq_pkg::flags_b_off) ||
               (paddr == pirq_pkg::enables_a_off) ||
               (paddr == pirq_pkg::enables_b_off) ||
               (paddr == pirq_pkg::prio_a_off) ||
               (paddr == pirq_pkg::prio_b_off) ||
               (paddr == pirq_pkg::core_ctrl_off) ||
               (paddr == pirq_pkg::request_off);

  // ==========================================================================
  // event sources onto flag positions
  assign ccp_mode = pirq_pkg::pirq_ccp_mode_type'(capcmp_mode);
  always_comb begin
    capcmp_set = 1'b0;
    case (ccp_mode)
      pirq_pkg::pirq_ccp_capture: capcmp_set = timer_a_capture;
      pirq_pkg::pirq_ccp_compare: capcmp_set = timer_a_compare;
      default: capcmp_set = 1'b0; // unused in pulse-width and off modes
    endcase
  end

  // bank a positions, timer a and b flags set here, timer c in bank b
  always_comb begin
    set_a = 8'h00;
    set_a[pirq_pkg::converter_done_bit] = converter_done;
    set_a[pirq_pkg::sync_port_done_bit] = sync_port_done;
    set_a[pirq_pkg::capcmp_event_bit] = capcmp_set;
    set_a[pirq_pkg::timer_b_match_bit] = timer_b_match;
    set_a[pirq_pkg::timer_a_overflow_bit] = timer_a_overflow;
    lvl_a = 8'h00;
    lvl_a[pirq_pkg::rx_full_bit] = rx_buffer_full;
    lvl_a[pirq_pkg::tx_empty_bit] = tx_buffer_empty;
  end

  always_comb begin
    set_b = 8'h00;
    set_b[pirq_pkg::osc_fail_bit] = osc_fail;
    set_b[pirq_pkg::comparator_one_bit] = comparator_one;
    set_b[pirq_pkg::comparator_two_bit] = comparator_two;
    set_b[pirq_pkg::nv_write_done_bit] = nv_write_done;
    set_b[pirq_pkg::bus_collision_bit] = bus_collision;
    set_b[pirq_pkg::usb_request_bit] = usb_request;
    set_b[pirq_pkg::timer_c_overflow_bit] = timer_c_overflow;
  end

  // flag register a, rx/tx bits follow buffer levels
  pirq_flag_bank #(
    .impl_mask(pirq_pkg::mask_a),
    .wr_mask(pirq_pkg::flag_wr_mask_a)
  ) u_flags_a (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .event_set(set_a),
    .level_val(lvl_a),
    .level_sel(pirq_pkg::mask_a & ~pirq_pkg::flag_wr_mask_a),
    .wr_en(wr_flags_a),
    .wr_data(pwdata[7:0]),
    .flags(flags_a)
  );

  // flag register b, all implemented bits sticky
  pirq_flag_bank #(
    .impl_mask(pirq_pkg::mask_b),
    .wr_mask(pirq_pkg::mask_b)
  ) u_flags_b (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .event_set(set_b),
    .level_val(8'h00),
    .level_sel(8'h00),
    .wr_en(wr_flags_b),
    .wr_data(pwdata[7:0]),
    .flags(flags_b)
  );

  // request routing by enables and priority
  pirq_router u_router (
    .flags({flags_b, flags_a}),
    .enables({st_reg.enables_b_reg, st_reg.enables_a_reg}),
    .prios({st_reg.prio_b_reg, st_reg.prio_a_reg}),
    .prio_en(st_reg.core_ctrl_reg[pirq_pkg::priority_levels_enable_bit]),
    .gen_high(st_reg.core_ctrl_reg[pirq_pkg::high_level_global_enable_bit]),
    .gen_low(st_reg.core_ctrl_reg[pirq_pkg::low_level_global_enable_bit]),
    .req_high(route_high),
    .req_low(route_low)
  );

  // ==========================================================================
  // register writes, read mux and registered requests
  always_comb begin
    st_next = st_reg;
    if (clk_en) begin
      st_next.req_high_reg = route_high;
      st_next.req_low_reg = route_low;
      if (psel && penable) begin
        st_next.slverr_reg = !hit;
      end else begin
        st_next.slverr_reg = 1'b0;
      end
      if (wr_access) begin
        case (paddr)
          pirq_pkg::enables_a_off:
            st_next.enables_a_reg = pwdata[7:0] & pirq_pkg::mask_a;
          pirq_pkg::enables_b_off:
            st_next.enables_b_reg = pwdata[7:0] & pirq_pkg::mask_b;
          pirq_pkg::prio_a_off:
            st_next.prio_a_reg = pwdata[7:0] & pirq_pkg::mask_a;
          pirq_pkg::prio_b_off:
            st_next.prio_b_reg = pwdata[7:0] & pirq_pkg::mask_b;
          pirq_pkg::core_ctrl_off:
            st_next.core_ctrl_reg = pwdata[2:0];
          default: st_next.core_ctrl_reg = st_reg.core_ctrl_reg;
        endcase
      end
      if (psel && !penable && !pwrite) begin
        case (paddr)
          pirq_pkg::flags_a_off: st_next.rdata_reg = {24'h000000, flags_a};
          pirq_pkg::flags_b_off: st_next.rdata_reg = {24'h000000, flags_b};
          pirq_pkg::enables_a_off:
            st_next.rdata_reg = {24'h000000, st_reg.enables_a_reg};
          pirq_pkg::enables_b_off:
            st_next.rdata_reg = {24'h000000, st_reg.enables_b_reg};
          pirq_pkg::prio_a_off:
            st_next.rdata_reg = {24'h000000, st_reg.prio_a_reg};
          pirq_pkg::prio_b_off:
            st_next.rdata_reg = {24'h000000, st_reg.prio_b_reg};
          pirq_pkg::core_ctrl_off:
            st_next.rdata_reg = {29'h00000000, st_reg.core_ctrl_reg};
          pirq_pkg::request_off:
            st_next.rdata_reg = {30'h00000000, route_low, route_high};
          default: st_next.rdata_reg = 32'h00000000;
        endcase
      end
    end
  end

  // state register with documented reset values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg.enables_a_reg <= pirq_pkg::enables_rst;
      st_reg.enables_b_reg <= pirq_pkg::enables_rst;
      st_reg.prio_a_reg <= pirq_pkg::prio_a_rst;
      st_reg.prio_b_reg <= pirq_pkg::prio_b_rst;
      st_reg.core_ctrl_reg <= pirq_pkg::core_ctrl_rst;
      st_reg.rdata_reg <= 32'h00000000;
      st_reg.slverr_reg <= 1'b0;
      st_reg.req_high_reg <= 1'b0;
      st_reg.req_low_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign req_high = st_reg.req_high_reg;
  assign req_low = st_reg.req_low_reg;

  // ==========================================================================
  // checks
  sequence s_usb_seen;
    clk_en && usb_request;
  endsequence
  sequence s_usb_held;
    !(wr_flags_b && !pwdata[pirq_pkg::usb_request_bit]) [*3];
  endsequence
  a_usb_sticky: assert property (@(posedge pclk)
    disable iff (!presetn)
    s_usb_seen ##1 s_usb_held |-> flags_b[pirq_pkg::usb_request_bit])
    else $error("usb flag dropped without clear");
  a_no_group_gate: assert property (@(posedge pclk)
    disable iff (!presetn)
    (clk_en && !st_reg.core_ctrl_reg[0] && !st_reg.core_ctrl_reg[2])
    |=> !req_high && !req_low)
    else $error("request without group enable");
  a_single_level: assert property (@(posedge pclk)
    disable iff (!presetn)
    (clk_en && !st_reg.core_ctrl_reg[0]) |=> !req_low)
    else $error("low request without levels");
  a_rx_follows: assert property (@(posedge pclk)
    disable iff (!presetn)
    clk_en |=> flags_a[pirq_pkg::rx_full_bit] == $past(rx_buffer_full))
    else $error("rx flag not following buffer");
  a_tx_follows: assert property (@(posedge pclk)
    disable iff (!presetn)
    clk_en |=> flags_a[pirq_pkg::tx_empty_bit] == $past(tx_buffer_empty))
    else $error("tx flag not following buffer");
  a_pwm_no_set: assert property (@(posedge pclk)
    disable iff (!presetn)
    (clk_en && capcmp_mode == 2'b10 && !flags_a[2] && !wr_flags_a)
    |=> !flags_a[pirq_pkg::capcmp_event_bit])
    else $error("capcmp flag set in pwm mode");
  a_high_route: assert property (@(posedge pclk)
    disable iff (!presetn)
    (clk_en && st_reg.core_ctrl_reg == 3'h3 &&
     |(flags_a & st_reg.enables_a_reg & st_reg.prio_a_reg))
    |=> req_high)
    else $error("high request missing");
  // low level path: levels on, only the low global enable set
  a_low_route: assert property (@(posedge pclk)
    disable iff (!presetn)
    (clk_en && st_reg.core_ctrl_reg == 3'h5 &&
     |(flags_b & st_reg.enables_b_reg & ~st_reg.prio_b_reg))
    |=> req_low)
    else $error("low request missing");
  a_timer_hold: assert property (@(posedge pclk)
    disable iff (!presetn)
    (flags_a[pirq_pkg::timer_a_overflow_bit] && !wr_flags_a)
    |=> flags_a[pirq_pkg::timer_a_overflow_bit])
    else $error("timer flag cleared itself");
  a_enable_bits: assert property (@(posedge pclk)
    disable iff (!presetn)
    !st_reg.enables_a_reg[7] && !st_reg.enables_b_reg[0] &&
    !st_reg.prio_a_reg[7] && !st_reg.prio_b_reg[0])
    else $error("unimplemented bit set");
endmodule : pirq_top

//--- test/pirq_src_model.sv
// partner model: peripheral event sources pulsing the irq inputs
`timescale 1ns/1ps
module pirq_src_model (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, low
  input wire logic [12:0] fire, // source triggers from the bench
  output logic [12:0] pulse // one-cycle event pulses
);
  logic [12:0] fire_reg;
  // ==========================================================================
  // edge detect: a held trigger still gives a single one-cycle event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fire_reg <= '0;
      pulse <= '0;
    end else begin
      fire_reg <= fire;
      pulse <= fire & ~fire_reg;
    end
  end
endmodule : pirq_src_model

//--- test/tb_pirq_top.sv
// testbench: apb register, event flag and request routing checks
`timescale 1ns/1ps
module tb_pirq_top;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
  logic rx_buffer_full, tx_buffer_empty, req_high, req_low, h, l;
  logic [1:0] capcmp_mode;
  logic [3:0] pstrb;
  logic [7:0] paddr;
  logic [12:0] fire, ev;
  logic [15:0] act, pr;
  logic [31:0] pwdata, prdata, v, e, c;
  logic [31:0] exp_q[$];
  logic err_chk, err_exp;
  int fail_count = 0;
  int comparisons = 0;
  // source index to {flags_b, flags_a} bit
  localparam logic [15:0] src_map [13] = '{16'h0001, 16'h0002, 16'h0008,
    16'h0040, 16'h0200, 16'h0400, 16'h0800, 16'h1000, 16'h2000, 16'h4000,
    16'h8000, 16'h0004, 16'h0004};
  localparam logic [7:0] rst_v [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h7f,
    8'hfe, 8'h00, 8'h00};
  localparam logic [7:0] msk [6] = '{8'h4f, 8'hfe, 8'h7f, 8'hfe, 8'h7f,
    8'hfe};
  // ==========================================================================
  // design, source model, clock
  pirq_top DUT (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .rx_buffer_full,
    .tx_buffer_empty, .capcmp_mode, .req_high, .req_low,
    .timer_a_overflow(ev[0]), .timer_b_match(ev[1]),
    .sync_port_done(ev[2]), .converter_done(ev[3]),
    .timer_c_overflow(ev[4]), .usb_request(ev[5]), .bus_collision(ev[6]),
    .nv_write_done(ev[7]), .comparator_two(ev[8]),
    .comparator_one(ev[9]), .osc_fail(ev[10]), .timer_a_capture(ev[11]),
    .timer_a_compare(ev[12]));
  pirq_src_model SRC (.pclk(pclk), .presetn(presetn), .fire(fire),
    .pulse(ev));
  always #2 pclk = ~pclk;
  // ==========================================================================
  // tasks
  task stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  // one apb transfer, entered just after a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] x);
    exp_q.push_back({24'h0, x});
    apb(1'b0, a, 32'h0);
  endtask : rd
  task chk_req(input logic hi, input logic lo);
    cmp({30'h0, req_low, req_high}, {30'h0, lo, hi});
  endtask : chk_req
  task pulse_src(input logic [12:0] f);
    fire <= f;
    repeat (4) @(posedge pclk);
    fire <= '0;
  endtask : pulse_src
  // ==========================================================================
  // read data watcher: oldest note against the access-edge data
  always @(posedge pclk) begin
    if (err_chk === 1'b1) begin
      cmp({31'h0, pslverr}, {31'h0, err_exp}); // error flag after access
    end
    err_chk <= psel && penable && pready === 1'b1;
    err_exp <= (paddr > pirq_pkg::request_off) || (paddr[1:0] != 2'b00);
    if (psel && penable && !pwrite && pready === 1'b1) begin
      cmp(prdata, exp_q.pop_front());
    end
  end
  // watchdog against a hung handshake
  initial begin
    repeat (30000) @(posedge pclk);
    fail_count++;
    stop_test();
  end
  // ==========================================================================
  // main sequence
  initial begin
    {pclk, presetn, psel, penable, pwrite, rx_buffer_full} = '0;
    {tx_buffer_empty, capcmp_mode, fire, paddr, pwdata} = '0;
    clk_en = 1'b1;
    pstrb = 4'hf;
    void'($urandom(32'hb31ee29c));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 8; i++) rd(8'(4 * i), rst_v[i]);
    for (int i = 0; i < 6; i++) begin
      wr(8'(4 * i), 8'hff);
      rd(8'(4 * i), msk[i]);
      wr(8'(4 * i), 8'h00);
      rd(8'(4 * i), 8'h00);
    end
    wr(pirq_pkg::request_off, 8'hff);
    rd(pirq_pkg::request_off, 8'h00);
    rd(8'h20, 8'h00);
    clk_en <= 1'b0;
    wr(pirq_pkg::prio_a_off, 8'h55);
    clk_en <= 1'b1;
    rd(pirq_pkg::prio_a_off, 8'h00);
    $display("test registers done");
    wr(pirq_pkg::enables_a_off, 8'hff);
    wr(pirq_pkg::enables_b_off, 8'hff);
    wr(pirq_pkg::core_ctrl_off, 8'h02);
    for (int i = 0; i < 13; i++) begin
      capcmp_mode <= (i == 12) ? 2'b01 : 2'b00;
      pulse_src(13'h1 << i);
      chk_req(1'b0, 1'b0);
      rd(pirq_pkg::flags_a_off, src_map[i][7:0]);
      rd(pirq_pkg::flags_b_off, src_map[i][15:8]);
      wr(pirq_pkg::flags_a_off, 8'h00);
      wr(pirq_pkg::flags_b_off, 8'h00);
    end
    for (int m = 2; m < 4; m++) begin
      capcmp_mode <= 2'(m);
      pulse_src(13'h1800);
      rd(pirq_pkg::flags_a_off, 8'h00);
    end
    $display("test events done");
    rx_buffer_full <= 1'b1;
    repeat (2) @(posedge pclk);
    wr(pirq_pkg::flags_a_off, 8'h00);
    rd(pirq_pkg::flags_a_off, 8'h20);
    rx_buffer_full <= 1'b0;
    tx_buffer_empty <= 1'b1;
    repeat (2) @(posedge pclk);
    wr(pirq_pkg::flags_a_off, 8'hff);
    rd(pirq_pkg::flags_a_off, 8'h5f);
    tx_buffer_empty <= 1'b0;
    wr(pirq_pkg::flags_a_off, 8'h00);
    rd(pirq_pkg::flags_a_off, 8'h00);
    fire <= 13'h0001;
    wr(pirq_pkg::flags_a_off, 8'h00);
    fire <= '0;
    rd(pirq_pkg::flags_a_off, 8'h01);
    $display("test buffers and collision done");
    for (int n = 0; n < 40; n++) begin
      v = $urandom;
      e = $urandom;
      c = $urandom;
      wr(pirq_pkg::flags_a_off, v[7:0]);
      wr(pirq_pkg::flags_b_off, v[15:8]);
      wr(pirq_pkg::enables_a_off, e[7:0]);
      wr(pirq_pkg::enables_b_off, e[15:8]);
      wr(pirq_pkg::prio_a_off, e[23:16]);
      wr(pirq_pkg::prio_b_off, e[31:24]);
      wr(pirq_pkg::core_ctrl_off, {5'h0, c[2:0]});
      act = v[15:0] & e[15:0] & 16'hfe4f;
      pr = e[31:16];
      h = c[0] ? (|(act & pr)) & c[1] : (|act) & c[1] & c[2];
      l = c[0] ? (|(act & ~pr)) & c[2] : 1'b0;
      repeat (2) @(posedge pclk);
      chk_req(h, l);
      rd(pirq_pkg::request_off, {6'h0, l, h});
    end
    $display("test routing done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 8; i++) rd(8'(4 * i), rst_v[i]);
    $display("test mid-run reset done");
    stop_test();
  end
endmodule : tb_pirq_top
